// *** verilog/serial_8b10b_dword_framing.sv ***
`timescale 1ns/10ps

// ------------------------------------------------------------------
// transmit word buffer
// ------------------------------------------------------------------
module tx_word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) next_count = count + (AW+1)'(1);
    if (pop && !push) next_count = count - (AW+1)'(1);
  end

  // storage write
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  // pointers and flags, both registered
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= AW'((32'(wr_ptr) + 1) % DEPTH);
      if (pop) rd_ptr <= AW'((32'(rd_ptr) + 1) % DEPTH);
      count <= next_count;
      in_ready <= (32'(next_count) != DEPTH);
      out_valid <= (next_count != '0);
    end
  end
endmodule // tx_word_fifo

// ------------------------------------------------------------------
// character coder, dword framer and receive checker
// ------------------------------------------------------------------
module serial_8b10b_dword_framing (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // transmit words from link layer
  input wire logic [31:0] tx_data,
  input wire logic tx_prim,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic align_req,
  input wire logic rx_status_ok,
  // serial line
  output logic tx_bit,
  input wire logic rx_line,
  // received dword stream
  output logic [31:0] rx_word,
  output logic rx_word_prim,
  output logic rx_word_viol,
  output logic rx_word_valid,
  output logic rx_aligned,
  // received frame content
  output logic [31:0] rx_payload,
  output logic rx_payload_valid,
  output logic [31:0] rx_crc,
  output logic rx_crc_valid,
  output logic rx_in_frame,
  output logic rx_hold_seen,
  output logic rx_wtrm_seen,
  // link quality counters
  output logic [15:0] code_viol_count,
  output logic [15:0] disp_err_count
);
  // ----------------------------------------------------------------
  // coding functions
  // ----------------------------------------------------------------
  // ones in a six-bit group
  function automatic logic [2:0] ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) n = n + {2'h0, v[i]};
    return n;
  endfunction

  // encode one byte; returns {rd_out, code}, rd 1 means positive
  function automatic logic [10:0] encode(input logic [7:0] b, input logic k, input logic rd);
    logic [5:0] six;
    logic [3:0] four;
    logic [4:0] x;
    logic [2:0] y;
    logic rd6;
    logic rdo;
    x = b[4:0];
    y = b[7:5];
    six = 6'h00;
    four = 4'h0;
    rd6 = rd;
    rdo = rd;
    case (x)
      5'h00: six = 6'h27; 5'h01: six = 6'h1d; 5'h02: six = 6'h2d; 5'h03: six = 6'h31;
      5'h04: six = 6'h35; 5'h05: six = 6'h29; 5'h06: six = 6'h19; 5'h07: six = 6'h38;
      5'h08: six = 6'h39; 5'h09: six = 6'h25; 5'h0a: six = 6'h15; 5'h0b: six = 6'h34;
      5'h0c: six = 6'h0d; 5'h0d: six = 6'h2c; 5'h0e: six = 6'h1c; 5'h0f: six = 6'h17;
      5'h10: six = 6'h1b; 5'h11: six = 6'h23; 5'h12: six = 6'h13; 5'h13: six = 6'h32;
      5'h14: six = 6'h0b; 5'h15: six = 6'h2a; 5'h16: six = 6'h1a; 5'h17: six = 6'h3a;
      5'h18: six = 6'h33; 5'h19: six = 6'h26; 5'h1a: six = 6'h16; 5'h1b: six = 6'h36;
      5'h1c: six = 6'h0e; 5'h1d: six = 6'h2e; 5'h1e: six = 6'h1e; default: six = 6'h2b;
    endcase
    // 6-bit sub-block disparity
    if (ones(six) != 3'h3) begin
      if (rd) six = ~six;
      rd6 = ~rd;
    end else if (x == 5'h07 && rd) begin
      six = ~six;
    end
    case (y)
      3'h0: four = 4'hb; 3'h1: four = 4'h9; 3'h2: four = 4'h5; 3'h3: four = 4'hc;
      3'h4: four = 4'hd; 3'h5: four = 4'ha; 3'h6: four = 4'h6;
      default: begin
        if ((!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
            (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e))) four = 4'h7;
        else four = 4'he;
      end
    endcase
    // 4-bit sub-block disparity
    rdo = rd6;
    if (ones({2'h0, four}) != 3'h2) begin
      if (rd6) four = ~four;
      rdo = ~rd6;
    end else if (y == 3'h3 && rd6) begin
      four = ~four;
    end
    // control characters invert the disparity
    if (k) begin
      if (b == link_code_pkg::K285_BYTE) return {~rd, rd ? link_code_pkg::K285_POS :
                                                 link_code_pkg::K285_NEG};
      return {~rd, rd ? link_code_pkg::K283_POS : link_code_pkg::K283_NEG};
    end
    return {rdo, six, four};
  endfunction

  // decode one character; returns {viol, disp_err, rd_out, k, byte}
  function automatic logic [11:0] decode(input logic [9:0] c, input logic rd);
    logic [10:0] e;
    logic hit;
    logic k;
    logic [7:0] b;
    logic [2:0] n6;
    logic [2:0] n4;
    logic rd6;
    logic rdo;
    logic derr;
    hit = 1'b0;
    k = 1'b0;
    b = 8'h00;
    // search only the column of the current disparity
    for (int i = 0; i < 256; i++) begin
      e = encode(8'(i), 1'b0, rd);
      if (!hit && e[9:0] == c) begin
        hit = 1'b1;
        b = 8'(i);
      end
    end
    if (c == (rd ? link_code_pkg::K283_POS : link_code_pkg::K283_NEG)) begin
      hit = 1'b1;
      k = 1'b1;
      b = link_code_pkg::K283_BYTE;
    end
    if (c == (rd ? link_code_pkg::K285_POS : link_code_pkg::K285_NEG)) begin
      hit = 1'b1;
      k = 1'b1;
      b = link_code_pkg::K285_BYTE;
    end
    // disparity from the bits themselves, valid or not
    n6 = ones(c[9:4]);
    n4 = ones({2'h0, c[3:0]});
    derr = 1'b0;
    rd6 = rd;
    if (n6 > 3'h3) begin
      derr = rd;
      rd6 = 1'b1;
    end else if (n6 < 3'h3) begin
      derr = !rd;
      rd6 = 1'b0;
    end
    rdo = rd6;
    if (n4 > 3'h2) begin
      derr = derr | rd6;
      rdo = 1'b1;
    end else if (n4 < 3'h2) begin
      derr = derr | !rd6;
      rdo = 1'b0;
    end
    return {!hit, derr, rdo, k, b};
  endfunction

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  logic [32:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] tx_word;
  logic [9:0] tx_shift;
  logic [3:0] tx_bcnt;
  logic [1:0] tx_idx;
  logic tx_rd;
  logic align_pend;
  logic align_second;
  logic word_end;
  logic send_align;
  logic [31:0] next_word;
  logic next_prim;
  logic [1:0] next_idx;
  logic [7:0] next_byte;
  logic next_k;
  logic [10:0] next_code;

  tx_word_fifo #(
    .WIDTH(link_code_pkg::FIFO_WIDTH),
    .DEPTH(link_code_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_data({tx_prim, tx_data}),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign word_end = (tx_bcnt == link_code_pkg::BIT_LAST) && (tx_idx == link_code_pkg::BYTE_LAST);
  assign send_align = align_second || align_pend;

  // choose the next dword at each dword boundary
  always_comb begin
    next_word = link_code_pkg::PRIM_SYNC;
    next_prim = 1'b1;
    fifo_pop = 1'b0;
    if (send_align) begin
      next_word = link_code_pkg::PRIM_ALIGN;
    end else if (rx_hold_seen) begin
      next_word = link_code_pkg::PRIM_HOLDA;
    end else if (rx_wtrm_seen) begin
      next_word = rx_status_ok ? link_code_pkg::PRIM_ROK : link_code_pkg::PRIM_RERR;
    end else if (fifo_valid) begin
      next_word = fifo_data[31:0];
      next_prim = fifo_data[32];
      fifo_pop = word_end;
    end
  end

  // next character to encode, byte 0 first
  always_comb begin
    next_idx = word_end ? 2'h0 : tx_idx + 2'h1;
    next_byte = word_end ? next_word[7:0] : tx_word[8*next_idx +: 8];
    next_k = word_end && next_prim;
    next_code = encode(next_byte, next_k, tx_rd);
  end

  // align requests become pairs
  always_ff @(posedge clock) begin
    if (!rstn) begin
      align_pend <= 1'b0;
      align_second <= 1'b0;
    end else begin
      align_pend <= (align_pend && !(word_end && !align_second)) || align_req;
      if (word_end) align_second <= send_align && !align_second;
    end
  end

  // serializer, a first and j last
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_word <= link_code_pkg::PRIM_SYNC;
      tx_shift <= 10'h000;
      tx_bcnt <= link_code_pkg::BIT_LAST;
      tx_idx <= link_code_pkg::BYTE_LAST;
      tx_rd <= 1'b0;
      tx_bit <= 1'b0;
    end else if (tx_bcnt == link_code_pkg::BIT_LAST) begin
      if (word_end) tx_word <= next_word;
      tx_idx <= next_idx;
      tx_bcnt <= 4'h0;
      tx_rd <= next_code[10];
      tx_bit <= next_code[9];
      tx_shift <= {next_code[8:0], 1'b0};
    end else begin
      tx_bcnt <= tx_bcnt + 4'h1;
      tx_bit <= tx_shift[9];
      tx_shift <= {tx_shift[8:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // receive character path
  // ----------------------------------------------------------------
  logic rx_sync1;
  logic rx_sync2;
  logic [9:0] rx_shift;
  logic [3:0] rx_bcnt;
  logic [1:0] rx_idx;
  logic rx_rd;
  logic [23:0] rx_low;
  logic rx_low_prim;
  logic rx_low_viol;
  logic comma;
  logic char_now;
  logic [11:0] dec;

  assign comma = (rx_shift == link_code_pkg::K285_NEG) || (rx_shift == link_code_pkg::K285_POS);
  assign char_now = comma || (rx_aligned && rx_bcnt == link_code_pkg::BIT_LAST);
  assign dec = decode(rx_shift, rx_rd);

  // line synchronizer and shifter, newest bit lowest
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_sync1 <= 1'b0;
      rx_sync2 <= 1'b0;
      rx_shift <= 10'h000;
    end else begin
      rx_sync1 <= rx_line;
      rx_sync2 <= rx_sync1;
      rx_shift <= {rx_shift[8:0], rx_sync2};
    end
  end

  // character boundary and disparity
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_bcnt <= 4'h0;
      rx_aligned <= 1'b0;
      rx_rd <= 1'b0;
    end else if (char_now) begin
      rx_bcnt <= 4'h0;
      if (comma) rx_aligned <= 1'b1;
      rx_rd <= dec[9];
    end else if (rx_bcnt != link_code_pkg::BIT_LAST) begin
      rx_bcnt <= rx_bcnt + 4'h1;
    end
  end

  // dword assembly, comma is byte 0
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_idx <= 2'h0;
      rx_low <= 24'h000000;
      rx_low_prim <= 1'b0;
      rx_low_viol <= 1'b0;
      rx_word <= 32'h00000000;
      rx_word_prim <= 1'b0;
      rx_word_viol <= 1'b0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (char_now) begin
        if (comma || rx_idx == 2'h0) begin
          rx_idx <= 2'h1;
          rx_low[7:0] <= dec[7:0];
          rx_low_prim <= dec[8];
          rx_low_viol <= dec[11];
        end else if (rx_idx == link_code_pkg::BYTE_LAST) begin
          rx_idx <= 2'h0;
          rx_word <= {dec[7:0], rx_low};
          rx_word_prim <= rx_low_prim;
          rx_word_viol <= rx_low_viol || dec[11];
          rx_word_valid <= 1'b1;
        end else begin
          rx_idx <= rx_idx + 2'h1;
          rx_low[8*rx_idx +: 8] <= dec[7:0];
          rx_low_viol <= rx_low_viol || dec[11];
        end
      end
    end
  end

  // saturating quality counters
  always_ff @(posedge clock) begin
    if (!rstn) begin
      code_viol_count <= 16'h0000;
      disp_err_count <= 16'h0000;
    end else if (char_now) begin
      if (dec[11] && code_viol_count != link_code_pkg::COUNT_MAX)
        code_viol_count <= code_viol_count + 16'h0001;
      if (dec[10] && disp_err_count != link_code_pkg::COUNT_MAX)
        disp_err_count <= disp_err_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // receive frame path
  // ----------------------------------------------------------------
  logic [31:0] pend;
  logic pend_valid;
  logic cont_active;

  // frame tracking, one dword held back as crc candidate
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pend <= 32'h00000000;
      pend_valid <= 1'b0;
      cont_active <= 1'b0;
      rx_in_frame <= 1'b0;
      rx_payload <= 32'h00000000;
      rx_payload_valid <= 1'b0;
      rx_crc <= 32'h00000000;
      rx_crc_valid <= 1'b0;
    end else begin
      rx_payload_valid <= 1'b0;
      rx_crc_valid <= 1'b0;
      if (rx_word_valid && rx_word_prim) begin
        if (rx_word != link_code_pkg::PRIM_ALIGN)
          cont_active <= (rx_word == link_code_pkg::PRIM_CONT);
        if (rx_word == link_code_pkg::PRIM_SOF) begin
          rx_in_frame <= 1'b1;
          pend_valid <= 1'b0;
        end else if (rx_word == link_code_pkg::PRIM_EOF && rx_in_frame) begin
          rx_in_frame <= 1'b0;
          pend_valid <= 1'b0;
          rx_crc <= pend;
          rx_crc_valid <= pend_valid;
        end
      end else if (rx_word_valid && rx_in_frame && !cont_active) begin
        pend <= rx_word;
        pend_valid <= 1'b1;
        rx_payload <= pend;
        rx_payload_valid <= pend_valid;
      end
    end
  end

  // handshake levels, no counting of primitives
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_hold_seen <= 1'b0;
      rx_wtrm_seen <= 1'b0;
    end else if (rx_word_valid && rx_word_prim && rx_word != link_code_pkg::PRIM_ALIGN &&
                 rx_word != link_code_pkg::PRIM_CONT) begin
      rx_hold_seen <= (rx_word == link_code_pkg::PRIM_HOLD);
      rx_wtrm_seen <= (rx_word == link_code_pkg::PRIM_WTRM);
    end
  end
endmodule // serial_8b10b_dword_framing

// *** verilog/link_code_pkg.sv ***
package link_code_pkg;
  // ----------------------------------------------------------------
  // character codes, abcdei fghj with a in bit 9
  // ----------------------------------------------------------------
  localparam logic [7:0] K283_BYTE = 8'h7c;
  localparam logic [7:0] K285_BYTE = 8'hbc;
  localparam logic [9:0] K283_NEG = 10'h0f3;
  localparam logic [9:0] K283_POS = 10'h30c;
  localparam logic [9:0] K285_NEG = 10'h0fa;
  localparam logic [9:0] K285_POS = 10'h305;
  // ----------------------------------------------------------------
  // primitive dwords; upper bytes arbitrary, byte 0 the control char
  // ----------------------------------------------------------------
  localparam logic [31:0] PRIM_ALIGN = 32'h7b4a_4abc;
  localparam logic [31:0] PRIM_SYNC = 32'hb5b5_957c;
  localparam logic [31:0] PRIM_SOF = 32'h3737_b57c;
  localparam logic [31:0] PRIM_EOF = 32'hd5d5_b57c;
  localparam logic [31:0] PRIM_HOLD = 32'hd5d5_aa7c;
  localparam logic [31:0] PRIM_HOLDA = 32'h9595_aa7c;
  localparam logic [31:0] PRIM_CONT = 32'h9999_aa7c;
  localparam logic [31:0] PRIM_WTRM = 32'h5858_b57c;
  localparam logic [31:0] PRIM_ROK = 32'h3535_b57c;
  localparam logic [31:0] PRIM_RERR = 32'h5656_b57c;
  // ----------------------------------------------------------------
  // counts and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam int FIFO_WIDTH = 33;
  localparam int FIFO_DEPTH = 8;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage

// *** dv/link_framing_props.sv ***
`timescale 1ns/10ps

// ----------------------------------------
// port checks for the dword framing block
// ----------------------------------------
module link_framing_props (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // received stream
  input wire logic [31:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic rx_aligned,
  input wire logic rx_payload_valid,
  input wire logic rx_crc_valid,
  input wire logic rx_in_frame,
  input wire logic rx_hold_seen,
  input wire logic rx_wtrm_seen,
  // link quality counters
  input wire logic [15:0] code_viol_count,
  input wire logic [15:0] disp_err_count
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // eight quiet cycles right after a dword
  sequence s_quiet_gap;
    !rx_word_valid [*8];
  endsequence

  a_word_period: assert property (
    rx_word_valid |=> s_quiet_gap ##32 rx_word_valid)
    else $error("dwords not 40 cycles apart");
  a_unaligned_mute: assert property (!rx_aligned |-> !rx_word_valid)
    else $error("dword before comma");
  a_aligned_sticks: assert property (rx_aligned |=> rx_aligned)
    else $error("alignment lost");
  a_payload_inside: assert property (rx_payload_valid |-> rx_in_frame)
    else $error("payload outside frame");
  a_crc_closes: assert property (rx_crc_valid |-> ##[0:1] !rx_in_frame)
    else $error("crc without frame end");
  a_frame_opens: assert property (
    $rose(rx_in_frame) |-> rx_word == link_code_pkg::PRIM_SOF)
    else $error("frame opened without start");
  a_frame_closes: assert property (
    $fell(rx_in_frame) |-> rx_word == link_code_pkg::PRIM_EOF)
    else $error("frame closed without end");
  a_hold_cause: assert property (
    $rose(rx_hold_seen) |-> rx_word == link_code_pkg::PRIM_HOLD)
    else $error("hold flag without hold");
  a_wtrm_cause: assert property (
    $rose(rx_wtrm_seen) |-> rx_word == link_code_pkg::PRIM_WTRM)
    else $error("wait flag without wait");
  a_viol_step: assert property (
    (code_viol_count - $past(code_viol_count)) <= 16'h0001)
    else $error("violation count jumped");
  a_disp_step: assert property (
    $changed(disp_err_count) |-> disp_err_count == $past(disp_err_count) + 16'h0001)
    else $error("disparity count jumped");
  a_viol_aligned: assert property ($changed(code_viol_count) |-> rx_aligned)
    else $error("violation before comma");
endmodule // link_framing_props

bind serial_8b10b_dword_framing link_framing_props u_props (
  .clock(clock), .rstn(rstn), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
  .rx_aligned(rx_aligned), .rx_payload_valid(rx_payload_valid), .rx_crc_valid(rx_crc_valid),
  .rx_in_frame(rx_in_frame), .rx_hold_seen(rx_hold_seen), .rx_wtrm_seen(rx_wtrm_seen),
  .code_viol_count(code_viol_count), .disp_err_count(disp_err_count));

// *** dv/far_link_model.sv ***
`timescale 1ns/10ps

// ----------------------------------------
// far end: turns the line round after a delay
// ----------------------------------------
module far_link_model (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // serial line
  input wire logic tx_bit,
  output logic rx_line,
  // fault control
  input wire logic flip_arm
);
  logic [23:0] dl;
  logic armed;

  // delay line, one planted error on a d21.1 d10.2 pair when armed
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dl <= 24'h000000;
      armed <= 1'h0;
    end else if (armed && dl[19:0] == 20'haa555) begin
      dl <= {dl[22:0], tx_bit} ^ 24'h001000;
      armed <= 1'h0;
    end else begin
      dl <= {dl[22:0], tx_bit};
      armed <= armed | flip_arm;
    end
  end
  assign rx_line = dl[23];
endmodule // far_link_model

// *** dv/serial_8b10b_dword_framing_tb_top.sv ***
`timescale 1ns/10ps

module serial_8b10b_dword_framing_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [31:0] tx_data = 32'h0;
  logic tx_prim = 1'h0;
  logic tx_valid = 1'h0;
  logic align_req = 1'h0;
  logic rx_status_ok = 1'h1;
  logic flip_arm = 1'h0;
  logic tx_ready, tx_bit, rx_line, rx_word_prim, rx_word_viol, rx_word_valid, rx_aligned;
  logic rx_payload_valid, rx_crc_valid, rx_in_frame, rx_hold_seen, rx_wtrm_seen;
  logic [31:0] rx_word, rx_payload, rx_crc;
  logic [15:0] code_viol_count, disp_err_count;
  logic [31:0] words[$], pays[$], crcs[$];
  logic prims[$];
  logic saw_viol = 1'h0;
  logic saw_full = 1'h0;
  int err_count = 0;
  int samples_checked = 0;

  // 20 mhz clock
  always #25 clock = ~clock;

  serial_8b10b_dword_framing uut (.clock(clock), .rstn(rstn), .tx_data(tx_data),
    .tx_prim(tx_prim), .tx_valid(tx_valid), .tx_ready(tx_ready), .align_req(align_req),
    .rx_status_ok(rx_status_ok), .tx_bit(tx_bit), .rx_line(rx_line), .rx_word(rx_word),
    .rx_word_prim(rx_word_prim), .rx_word_viol(rx_word_viol), .rx_word_valid(rx_word_valid),
    .rx_aligned(rx_aligned), .rx_payload(rx_payload), .rx_payload_valid(rx_payload_valid),
    .rx_crc(rx_crc), .rx_crc_valid(rx_crc_valid), .rx_in_frame(rx_in_frame),
    .rx_hold_seen(rx_hold_seen), .rx_wtrm_seen(rx_wtrm_seen),
    .code_viol_count(code_viol_count), .disp_err_count(disp_err_count));
  far_link_model far (.clock(clock), .rstn(rstn), .tx_bit(tx_bit), .rx_line(rx_line),
    .flip_arm(flip_arm));

  // collect received dwords, payload and crc
  always @(posedge clock) begin
    if (rx_word_valid === 1'h1) begin
      words.push_back(rx_word);
      prims.push_back(rx_word_prim);
      if (rx_word_viol === 1'h1) saw_viol = 1'h1;
    end
    if (rx_payload_valid === 1'h1) pays.push_back(rx_payload);
    if (rx_crc_valid === 1'h1) crcs.push_back(rx_crc);
    if (tx_valid === 1'h1 && tx_ready === 1'h0) saw_full = 1'h1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %b", $time, what, got);
    end
  endtask

  task automatic step(inout int n);
    @(posedge clock);
    n++;
    if (n > 3000) begin
      err_count++;
      $display("BAD %0t wait limit reached", $time);
      close_out();
    end
  endtask

  function automatic logic seen(input logic [31:0] w);
    foreach (words[i]) if (words[i] === w) return 1'h1;
    return 1'h0;
  endfunction

  // offer one word and hold it until taken
  task automatic push(input logic [31:0] w, input logic p);
    int n;
    n = 0;
    tx_data <= w;
    tx_prim <= p;
    tx_valid <= 1'h1;
    do step(n); while (tx_ready !== 1'h1);
  endtask

  task automatic stop_tx();
    tx_valid <= 1'h0;
    @(posedge clock);
  endtask

  task automatic clear_q();
    words.delete();
    prims.delete();
    pays.delete();
    crcs.delete();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset_idle();
    logic [9:0] sh;
    logic hit;
    sh = 10'h0;
    hit = 1'h0;
    repeat (14) begin
      @(posedge clock);
      sh = {sh[8:0], tx_bit};
      if (sh === link_code_pkg::K283_NEG) hit = 1'h1;
    end
    cmp_bit(hit, 1'h1, "first char a..j");
    repeat (100) @(posedge clock);
    cmp_bit(rx_aligned, 1'h0, "aligned without comma");
  endtask

  task automatic s_align();
    int n;
    n = 0;
    align_req <= 1'h1;
    @(posedge clock);
    align_req <= 1'h0;
    while (words.size() < 3) step(n);
    cmp_word(words[0], link_code_pkg::PRIM_ALIGN, "first word");
    cmp_bit(prims[0], 1'h1, "align is primitive");
    cmp_word(words[1], link_code_pkg::PRIM_ALIGN, "second align");
    cmp_word(words[2], link_code_pkg::PRIM_SYNC, "idle after pair");
    cmp_word({code_viol_count, disp_err_count}, 32'h0, "clean line");
  endtask

  task automatic s_fifo_fill();
    logic [31:0] exp[$];
    logic [31:0] got[$];
    int n;
    n = 0;
    clear_q();
    for (int i = 0; i < 10; i++) begin
      exp.push_back(32'h4433_2211 + 32'h0101_0101 * i);
      push(exp[i], 1'h0);
    end
    stop_tx();
    cmp_bit(saw_full, 1'h1, "full buffer refuses");
    while (!seen(exp[9])) step(n);
    foreach (words[j]) if (prims[j] === 1'h0) got.push_back(words[j]);
    cmp_word(32'(got.size()), 32'ha, "data dword count");
    foreach (exp[j]) cmp_word(got[j], exp[j], "dword bytes");
    cmp_word(32'(pays.size()), 32'h0, "payload outside frame");
    while (tx_ready !== 1'h1) step(n);
  endtask

  task automatic s_frame_hold();
    int n;
    n = 0;
    clear_q();
    push(link_code_pkg::PRIM_SOF, 1'h1);
    push(32'h1234_5678, 1'h0);
    push(link_code_pkg::PRIM_CONT, 1'h1);
    push(32'h5a5a_a5a5, 1'h0);
    push(link_code_pkg::PRIM_HOLD, 1'h1);
    push(32'h9abc_def0, 1'h0);
    push(32'h0f1e_2d3c, 1'h0);
    push(link_code_pkg::PRIM_EOF, 1'h1);
    stop_tx();
    while (crcs.size() == 0) step(n);
    cmp_word(32'(pays.size()), 32'h2, "payload count");
    cmp_word(pays[0], 32'h1234_5678, "payload 0");
    cmp_word(pays[1], 32'h9abc_def0, "payload 1");
    cmp_word(crcs[0], 32'h0f1e_2d3c, "crc dword");
    cmp_bit(seen(link_code_pkg::PRIM_HOLDA), 1'h1, "hold answered");
  endtask

  task automatic s_wtrm_answer();
    logic [31:0] exp;
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      rx_status_ok <= (k == 0);
      exp = (k == 0) ? link_code_pkg::PRIM_ROK : link_code_pkg::PRIM_RERR;
      clear_q();
      push(link_code_pkg::PRIM_WTRM, 1'h1);
      stop_tx();
      while (!seen(exp)) step(n);
      if (k == 0) cmp_bit(seen(link_code_pkg::PRIM_RERR), 1'h0, "wrong status");
    end
  endtask

  task automatic s_bit_error();
    logic [16:0] s0, s1, s2;
    int n;
    n = 0;
    s0 = code_viol_count + disp_err_count;
    saw_viol = 1'h0;
    flip_arm <= 1'h1;
    @(posedge clock);
    flip_arm <= 1'h0;
    push(32'h00b7_4a35, 1'h0);
    push(32'h5566_7788, 1'h0);
    stop_tx();
    while (!seen(32'h5566_7788)) step(n);
    cmp_bit(saw_viol, 1'h1, "violation flagged");
    s1 = code_viol_count + disp_err_count;
    cmp_bit(s1 > s0, 1'h1, "error counted");
    push(32'h1357_9bdf, 1'h0);
    push(32'h2468_ace0, 1'h0);
    stop_tx();
    while (!seen(32'h2468_ace0)) step(n);
    s2 = code_viol_count + disp_err_count;
    cmp_word({15'h0, s2}, {15'h0, s1}, "stream resynced");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    s_reset_idle();
    s_align();
    s_fifo_fill();
    s_frame_hold();
    s_wtrm_answer();
    s_bit_error();
    close_out();
  end
endmodule // serial_8b10b_dword_framing_tb_top
